/* File: hdl/viu_pkg.sv */
// Purpose: Shared constants for the virtual input and user output logic.
// Assumes: One 50 MHz clock; signal codes are eight bits wide.
// Notes: Register offsets are word indices on the plain register port.
package viu_pkg;
  // Clock and time base.
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  // Channel counts and widths.
  localparam int VIN_N = 4;
  localparam int UOUT_N = 2;
  localparam int CODE_W = 8;
  localparam int OUT_SIG_W = 256;
  localparam int IN_FUNC_W = 256;
  localparam int DEAD_W = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Signal codes and limits.
  localparam logic [CODE_W-1:0] CODE_CONST_OFF = 8'h80;
  localparam logic [CODE_W-1:0] FUNC_NONE = 8'h00;
  localparam logic [DEAD_W-1:0] DEAD_MAX = 8'hFA;
  // Reset values and the AND operation code.
  localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
  localparam logic INV_RST = 1'h0;
  localparam logic ONE_RST = 1'h0;
  localparam logic OP_RST = 1'h1;
  localparam logic OP_AND = 1'h0;
  // Register word indices.
  localparam logic [ADDR_W-1:0] ADDR_VIN0 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_UOUT0 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h06;
  // Virtual input word layout.
  localparam int VIN_SRC_LSB = 0;
  localparam int VIN_FUNC_LSB = 8;
  localparam int VIN_INV_BIT = 16;
  localparam int VIN_ONE_BIT = 17;
  localparam int VIN_DEAD_LSB = 24;
  // User output word layout.
  localparam int UO_SRCA_LSB = 0;
  localparam int UO_INVA_BIT = 8;
  localparam int UO_SRCB_LSB = 16;
  localparam int UO_INVB_BIT = 24;
  localparam int UO_OP_BIT = 25;
  // Status word layout.
  localparam int ST_VIN_LSB = 0;
  localparam int ST_UOUT_LSB = 4;
endpackage : viu_pkg

/* File: hdl/viu_vin_chan.sv */
// Purpose: One virtual input channel: inversion, ON dead time, one-shot.
// Assumes: Trigger is already selected and on the same clock.
// Notes: Dead time counts whole millisecond ticks, so the first may be short.
`timescale 1ns/10ps
module viu_vin_chan
  import viu_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ms_tick,
  // Channel settings and trigger.
  input wire logic trig,
  input wire logic invert,
  input wire logic [DEAD_W-1:0] dead_ms,
  input wire logic one_shot,
  // Channel result.
  output logic result
);
  logic [DEAD_W-1:0] cnt_ff;
  logic [DEAD_W-1:0] nxt_cnt;
  logic q_ff;
  logic nxt_q;
  logic res_ff;
  logic nxt_res;
  logic lvl;
  logic qual;

  // RULE15: invert, qualify, shape
  always_comb begin
    // RULE3: trigger inversion
    lvl = trig ^ invert;
    nxt_cnt = cnt_ff;
    // RULE4: ON dead time
    if (!lvl) begin
      nxt_cnt = DEAD_RST;
    end else if (ms_tick && cnt_ff < dead_ms) begin
      nxt_cnt = DEAD_W'(cnt_ff + 1'b1);
    end
    qual = lvl && (cnt_ff >= dead_ms);
    nxt_q = qual;
    // RULE5: one-shot mode select
    // RULE14: single pulse per edge
    nxt_res = one_shot ? (qual & ~q_ff) : qual;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= DEAD_RST;
      q_ff <= 1'b0;
      res_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      q_ff <= nxt_q;
      res_ff <= nxt_res;
    end
  end

  assign result = res_ff;

  inv_pass_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
    dead_ms == DEAD_RST && !one_shot |=> res_ff == $past(trig ^ invert))
    else $error("Inverted trigger not passed through.");
  dead_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    $rose(q_ff) |-> $past(cnt_ff) >= $past(dead_ms))
    else $error("Channel turned ON before dead time.");
  dead_block_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    (trig ^ invert) && dead_ms != DEAD_RST && cnt_ff == DEAD_RST |=> !q_ff)
    else $error("Dead time did not hold off the ON state.");
  shot_width_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    res_ff && one_shot && $past(one_shot) |=> !res_ff)
    else $error("One-shot pulse longer than one cycle.");
  shot_edge_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    one_shot && !q_ff && qual |=> res_ff)
    else $error("One-shot pulse missing on qualified edge.");
  dead_cov: cover property (@(posedge clk) disable iff (sys_rst)
    dead_ms != DEAD_RST && $rose(q_ff));
  shot_cov: cover property (@(posedge clk) disable iff (sys_rst) one_shot && res_ff);
endmodule : viu_vin_chan

/* File: hdl/viu_top.sv */
// Purpose: Virtual input channels and user outputs of the driver signal router.
// Assumes: Output signal list arrives on the same clock; codes index it directly.
// Notes: Code 128 always reads OFF whatever the list input holds.
// Functional notes
// RULE1: each virtual input drives one chosen function
// RULE2: trigger source selectable, resets to OFF
// RULE3: trigger inversion, default not inverted
// RULE4: ON dead time 0 to 250 ms
// RULE5: one-shot mode, default disabled
// RULE6: channels one to three same as first
// RULE7: user output source A, resets to OFF
// RULE8: source A optional inversion, default off
// RULE9: user output source B, resets to OFF
// RULE10: source B inversion independent of A
// RULE11: combine A and B, AND or OR
// RULE12: second user output, same settings
// RULE13: channel zero carries the same settings
// RULE14: one-shot turns ON edge into pulse
// RULE15: select, invert, qualify, shape, then route
`timescale 1ns/10ps
module viu_top
  import viu_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Internal output signal list.
  input wire logic [OUT_SIG_W-1:0] out_sig_in,
  // Input function drive.
  output logic [IN_FUNC_W-1:0] in_func_out,
  // Channel results.
  output logic virtual_input_ch0,
  output logic virtual_input_ch1,
  output logic virtual_input_ch2,
  output logic virtual_input_ch3,
  output logic user_output_ch0,
  output logic user_output_ch1
);
  // Virtual input settings.
  logic [CODE_W-1:0] vfunc_ff [VIN_N];
  logic [CODE_W-1:0] nxt_vfunc [VIN_N];
  logic [CODE_W-1:0] vsrc_ff [VIN_N];
  logic [CODE_W-1:0] nxt_vsrc [VIN_N];
  logic [DEAD_W-1:0] vdead_ff [VIN_N];
  logic [DEAD_W-1:0] nxt_vdead [VIN_N];
  logic [VIN_N-1:0] vinv_ff;
  logic [VIN_N-1:0] nxt_vinv;
  logic [VIN_N-1:0] vone_ff;
  logic [VIN_N-1:0] nxt_vone;
  // User output settings.
  logic [CODE_W-1:0] usa_ff [UOUT_N];
  logic [CODE_W-1:0] nxt_usa [UOUT_N];
  logic [CODE_W-1:0] usb_ff [UOUT_N];
  logic [CODE_W-1:0] nxt_usb [UOUT_N];
  logic [UOUT_N-1:0] uia_ff;
  logic [UOUT_N-1:0] nxt_uia;
  logic [UOUT_N-1:0] uib_ff;
  logic [UOUT_N-1:0] nxt_uib;
  logic [UOUT_N-1:0] uop_ff;
  logic [UOUT_N-1:0] nxt_uop;
  // Datapath state.
  logic [UOUT_N-1:0] uout_ff;
  logic [UOUT_N-1:0] nxt_uout;
  logic [IN_FUNC_W-1:0] func_ff;
  logic [IN_FUNC_W-1:0] nxt_func;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [31:0] div_ff;
  logic [31:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;
  logic [VIN_N-1:0] vtrig;
  logic [VIN_N-1:0] vin_res;
  logic [UOUT_N-1:0] cond_a;
  logic [UOUT_N-1:0] cond_b;
  logic [DEAD_W-1:0] wr_dead;

  // Reading code 128 as OFF keeps a stray list bit from leaking into defaults.
  function automatic logic pick_sig(input logic [CODE_W-1:0] code,
                                    input logic [OUT_SIG_W-1:0] sigs);
    pick_sig = (code == CODE_CONST_OFF) ? 1'b0 : sigs[code];
  endfunction : pick_sig

  // Millisecond time base.
  always_comb begin
    nxt_tick = 1'b0;
    nxt_div = 32'(div_ff + 1'b1);
    if (div_ff >= 32'(MS_DIV - 1)) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  // Register writes; out of range dead times are clamped to the maximum.
  always_comb begin
    wr_dead = reg_wdata[VIN_DEAD_LSB +: DEAD_W];
    if (wr_dead > DEAD_MAX) begin
      wr_dead = DEAD_MAX;
    end
    nxt_vfunc = vfunc_ff;
    nxt_vsrc = vsrc_ff;
    nxt_vdead = vdead_ff;
    nxt_vinv = vinv_ff;
    nxt_vone = vone_ff;
    nxt_usa = usa_ff;
    nxt_usb = usb_ff;
    nxt_uia = uia_ff;
    nxt_uib = uib_ff;
    nxt_uop = uop_ff;
    for (int i = 0; i < VIN_N; i++) begin
      if (reg_wr && reg_addr == ADDR_W'(ADDR_VIN0 + i)) begin
        // RULE1: function code
        nxt_vfunc[i] = reg_wdata[VIN_FUNC_LSB +: CODE_W];
        // RULE2: trigger source code
        nxt_vsrc[i] = reg_wdata[VIN_SRC_LSB +: CODE_W];
        // RULE3: inversion setting
        nxt_vinv[i] = reg_wdata[VIN_INV_BIT];
        // RULE4: dead time setting
        nxt_vdead[i] = wr_dead;
        // RULE5: one-shot setting
        nxt_vone[i] = reg_wdata[VIN_ONE_BIT];
      end
    end
    for (int u = 0; u < UOUT_N; u++) begin
      if (reg_wr && reg_addr == ADDR_W'(ADDR_UOUT0 + u)) begin
        // RULE7: source A code
        nxt_usa[u] = reg_wdata[UO_SRCA_LSB +: CODE_W];
        // RULE8: source A inversion
        nxt_uia[u] = reg_wdata[UO_INVA_BIT];
        // RULE9: source B code
        nxt_usb[u] = reg_wdata[UO_SRCB_LSB +: CODE_W];
        // RULE10: source B inversion
        nxt_uib[u] = reg_wdata[UO_INVB_BIT];
        // RULE11: logical operation
        nxt_uop[u] = reg_wdata[UO_OP_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < VIN_N; i++) begin
        vfunc_ff[i] <= FUNC_NONE;
        vsrc_ff[i] <= CODE_CONST_OFF;
        vdead_ff[i] <= DEAD_RST;
      end
      for (int u = 0; u < UOUT_N; u++) begin
        usa_ff[u] <= CODE_CONST_OFF;
        usb_ff[u] <= CODE_CONST_OFF;
      end
      vinv_ff <= {VIN_N{INV_RST}};
      vone_ff <= {VIN_N{ONE_RST}};
      uia_ff <= {UOUT_N{INV_RST}};
      uib_ff <= {UOUT_N{INV_RST}};
      uop_ff <= {UOUT_N{OP_RST}};
    end else begin
      vfunc_ff <= nxt_vfunc;
      vsrc_ff <= nxt_vsrc;
      vdead_ff <= nxt_vdead;
      vinv_ff <= nxt_vinv;
      vone_ff <= nxt_vone;
      usa_ff <= nxt_usa;
      usb_ff <= nxt_usb;
      uia_ff <= nxt_uia;
      uib_ff <= nxt_uib;
      uop_ff <= nxt_uop;
    end
  end

  // RULE6: identical channels one to three
  // RULE13: channel zero same structure
  for (genvar g = 0; g < VIN_N; g++) begin : g_vin
    // RULE2: trigger selection
    assign vtrig[g] = pick_sig(vsrc_ff[g], out_sig_in);
    viu_vin_chan u_chan (
      .clk(clk),
      .sys_rst(sys_rst),
      .ms_tick(tick_ff),
      .trig(vtrig[g]),
      .invert(vinv_ff[g]),
      .dead_ms(vdead_ff[g]),
      .one_shot(vone_ff[g]),
      .result(vin_res[g])
    );
  end

  // RULE12: both user outputs alike
  for (genvar g = 0; g < UOUT_N; g++) begin : g_uout
    // RULE8: conditioned source A
    assign cond_a[g] = pick_sig(usa_ff[g], out_sig_in) ^ uia_ff[g];
    // RULE10: conditioned source B
    assign cond_b[g] = pick_sig(usb_ff[g], out_sig_in) ^ uib_ff[g];
  end

  // Function drive and user outputs; two channels on one function are ORed.
  always_comb begin
    nxt_func = '0;
    // RULE1: route result to function
    for (int k = 1; k < IN_FUNC_W; k++) begin
      for (int i = 0; i < VIN_N; i++) begin
        if (vfunc_ff[i] == CODE_W'(k) && vin_res[i]) begin
          nxt_func[k] = 1'b1;
        end
      end
    end
    // RULE11: AND or OR combine
    for (int u = 0; u < UOUT_N; u++) begin
      nxt_uout[u] = (uop_ff[u] == OP_AND) ? (cond_a[u] & cond_b[u]) : (cond_a[u] | cond_b[u]);
    end
  end

  // Register reads; unmapped indices read zero.
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      for (int i = 0; i < VIN_N; i++) begin
        if (reg_addr == ADDR_W'(ADDR_VIN0 + i)) begin
          nxt_rdata[VIN_SRC_LSB +: CODE_W] = vsrc_ff[i];
          nxt_rdata[VIN_FUNC_LSB +: CODE_W] = vfunc_ff[i];
          nxt_rdata[VIN_INV_BIT] = vinv_ff[i];
          nxt_rdata[VIN_ONE_BIT] = vone_ff[i];
          nxt_rdata[VIN_DEAD_LSB +: DEAD_W] = vdead_ff[i];
        end
      end
      for (int u = 0; u < UOUT_N; u++) begin
        if (reg_addr == ADDR_W'(ADDR_UOUT0 + u)) begin
          nxt_rdata[UO_SRCA_LSB +: CODE_W] = usa_ff[u];
          nxt_rdata[UO_INVA_BIT] = uia_ff[u];
          nxt_rdata[UO_SRCB_LSB +: CODE_W] = usb_ff[u];
          nxt_rdata[UO_INVB_BIT] = uib_ff[u];
          nxt_rdata[UO_OP_BIT] = uop_ff[u];
        end
      end
      if (reg_addr == ADDR_STATUS) begin
        nxt_rdata[ST_VIN_LSB +: VIN_N] = vin_res;
        nxt_rdata[ST_UOUT_LSB +: UOUT_N] = uout_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      func_ff <= '0;
      uout_ff <= '0;
      rdata_ff <= '0;
    end else begin
      func_ff <= nxt_func;
      uout_ff <= nxt_uout;
      rdata_ff <= nxt_rdata;
    end
  end

  assign in_func_out = func_ff;
  assign reg_rdata = rdata_ff;
  assign user_output_ch0 = uout_ff[0];
  assign user_output_ch1 = uout_ff[1];
  assign virtual_input_ch0 = vin_res[0];
  assign virtual_input_ch1 = vin_res[1];
  assign virtual_input_ch2 = vin_res[2];
  assign virtual_input_ch3 = vin_res[3];

  func_route_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    vin_res[0] && vfunc_ff[0] != FUNC_NONE |=> in_func_out[$past(vfunc_ff[0])])
    else $error("Channel result not routed to its function.");
  func_none_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    in_func_out[0] == 1'b0)
    else $error("No-function code was driven.");
  src_default_a: assert property (@(posedge clk) // RULE2
    sys_rst |=> vsrc_ff[0] == CODE_CONST_OFF && vsrc_ff[3] == CODE_CONST_OFF
    && vfunc_ff[1] == FUNC_NONE && vdead_ff[2] == DEAD_RST && !vone_ff[3])
    else $error("Virtual input defaults wrong after reset.");
  trig_sel_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    vsrc_ff[1] != CODE_CONST_OFF |-> vtrig[1] == out_sig_in[vsrc_ff[1]])
    else $error("Trigger selection mismatch.");
  dead_clamp_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    vdead_ff[0] <= DEAD_MAX && vdead_ff[3] <= DEAD_MAX)
    else $error("Dead time above its maximum.");
  uout_default_a: assert property (@(posedge clk) // RULE11
    sys_rst |=> uop_ff == {UOUT_N{OP_RST}} && usa_ff[1] == CODE_CONST_OFF
    && usb_ff[0] == CODE_CONST_OFF && uia_ff == '0 && uib_ff == '0)
    else $error("User output defaults wrong after reset.");
  uout_comb_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
    ##1 user_output_ch0 == ($past(uop_ff[0]) ? $past(cond_a[0] | cond_b[0])
    : $past(cond_a[0] & cond_b[0])))
    else $error("User output zero combination wrong.");
  uout_inv_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
    usb_ff[1] == CODE_CONST_OFF && uop_ff[1] != OP_AND
    |=> user_output_ch1 == ($past(cond_a[1]) | $past(uib_ff[1])))
    else $error("Source B inversion wrong.");
  tick_rate_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    tick_ff |=> !tick_ff)
    else $error("Millisecond tick longer than one cycle.");
  rd_unmap_a: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr > ADDR_STATUS |=> reg_rdata == '0)
    else $error("Unmapped read not zero.");
  uout_cov: cover property (@(posedge clk) disable iff (sys_rst) $rose(user_output_ch1));
  route_cov: cover property (@(posedge clk) disable iff (sys_rst) |in_func_out);
  and_cov: cover property (@(posedge clk) disable iff (sys_rst) !uop_ff[0] && user_output_ch0);
endmodule : viu_top

/* File: test/viu_sig_model.sv */
// Purpose: Far-side model: the driver's output signal list and function users.
// Assumes: Signal levels change only just after a rising clock edge.
// Notes: Counts ON cycles of one watched function so pulses can be measured.
`timescale 1ns/10ps
module viu_sig_model
  import viu_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Function drive from the block.
  input wire logic [IN_FUNC_W-1:0] in_func_out,
  input wire logic [CODE_W-1:0] watch_code,
  output logic [15:0] on_cycles,
  // Output signal list into the block.
  output logic [OUT_SIG_W-1:0] out_sig_in
);
  logic clr = 1'h0;
  initial out_sig_in = {OUT_SIG_W{1'h0}};
  task automatic set_sig(input int code, input logic val);
    @(posedge clk);
    out_sig_in[code] <= val;
  endtask : set_sig
  task automatic clear_count;
    @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
  endtask : clear_count
  // A pulse that lasts longer than one cycle shows up as a count above one.
  always @(posedge clk) begin
    if (sys_rst || clr) begin
      on_cycles <= 16'h0000;
    end else if (in_func_out[watch_code] === 1'h1) begin
      on_cycles <= on_cycles + 16'h0001;
    end
  end
endmodule : viu_sig_model

/* File: test/tb.sv */
// Purpose: Self-checking bench for the virtual input and user output logic.
// Assumes: Millisecond base shortened to ten cycles.
// Notes: Dead-time bounds allow for the partial first tick.
`timescale 1ns/10ps
module tb;
  import viu_pkg::*;
  localparam int DIV = 10;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [OUT_SIG_W-1:0] out_sig_in;
  logic [IN_FUNC_W-1:0] in_func_out;
  logic [3:0] vin;
  logic [1:0] uout;
  logic [15:0] on_cycles;
  logic [7:0] watch_code = 8'h06;
  int n_errors = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  viu_top #(.MS_DIV(DIV)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_sig_in(out_sig_in), .in_func_out(in_func_out), .virtual_input_ch0(vin[0]),
    .virtual_input_ch1(vin[1]), .virtual_input_ch2(vin[2]), .virtual_input_ch3(vin[3]),
    .user_output_ch0(uout[0]), .user_output_ch1(uout[1]));
  viu_sig_model model_u (.clk(clk), .sys_rst(sys_rst), .in_func_out(in_func_out),
    .watch_code(watch_code), .on_cycles(on_cycles), .out_sig_in(out_sig_in));
  function automatic logic [31:0] vw(input logic [7:0] s, input logic [7:0] f,
                                     input logic i, input logic o, input logic [7:0] d);
    return {d, 6'h00, o, i, f, s};
  endfunction : vw
  function automatic logic [31:0] uw(input logic [7:0] sa, input logic ia,
                                     input logic [7:0] sb, input logic ib, input logic op);
    return {6'h00, op, ib, sb, 7'h00, ia, sa};
  endfunction : uw
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // A wait that runs out of its bound ends the run as a failure.
  task automatic wait_vin(input int ch, input int limit, output int n);
    n = 0;
    while (vin[ch] !== 1'h1 && n < limit) begin
      step(1);
      n++;
    end
    if (n >= limit) begin
      n_errors++;
      final_report();
    end
  endtask : wait_vin
  initial begin
    logic [31:0] d;
    logic [7:0] s;
    logic e;
    int n;
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    wr(8'h06, 32'hFFFFFFFF);
    wr(8'h07, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), d);
      if (i < 4) check(d, vw(CODE_CONST_OFF, FUNC_NONE, INV_RST, ONE_RST, DEAD_RST));
      else if (i < 6) check(d, uw(8'h80, 1'h0, 8'h80, 1'h0, 1'h1));
      else check(d, 32'h00000000);
    end
    for (int i = 0; i < 4; i++) begin
      s = 8'h0A + 8'(i);
      wr(8'(i), vw(s, s + 8'h0A, 1'h0, 1'h0, 8'h00));
      model_u.set_sig(int'(s), 1'h1);
      step(3);
      check(vin[i], 1'h1);
      check(in_func_out[s + 8'h0A], 1'h1);
      rd(8'h06, d);
      check(d, 32'h00000001 << i);
      wr(8'(i), vw(s, s + 8'h0A, 1'h1, 1'h0, 8'h00));
      step(3);
      check(vin[i], 1'h0);
      check(in_func_out[s + 8'h0A], 1'h0);
      check(in_func_out[0], 1'h0);
    end
    wr(8'h02, vw(8'h80, 8'h21, 1'h0, 1'h0, 8'h00));
    model_u.set_sig(128, 1'h1);
    step(3);
    check(vin[2], 1'h0);
    wr(8'h00, vw(8'h40, 8'h05, 1'h0, 1'h0, 8'h03));
    model_u.set_sig(64, 1'h1);
    wait_vin(0, 100, n);
    check(n >= 2 * DIV && n <= 3 * DIV + 4, 1'h1);
    model_u.set_sig(64, 1'h0);
    step(3);
    check(vin[0], 1'h0);
    wr(8'h01, vw(8'h41, 8'h06, 1'h0, 1'h1, 8'hFF));
    rd(8'h01, d);
    check(d, vw(8'h41, 8'h06, 1'h0, 1'h1, DEAD_MAX));
    model_u.clear_count();
    model_u.set_sig(65, 1'h1);
    wait_vin(1, 3000, n);
    check(n >= 249 * DIV && n <= 250 * DIV + 4, 1'h1);
    step(10);
    check(vin[1], 1'h0);
    check(on_cycles, 16'h0001);
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 32; k++) begin
        wr(8'h04 + 8'(u), uw(8'h50, k[0], 8'h51, k[1], k[2]));
        model_u.set_sig(80, k[3]);
        model_u.set_sig(81, k[4]);
        step(2);
        e = k[2] ? ((k[3] ^ k[0]) | (k[4] ^ k[1])) : ((k[3] ^ k[0]) & (k[4] ^ k[1]));
        check(uout[u], e);
      end
    end
    @(posedge clk);
    sys_rst <= 1'h1;
    step(2);
    sys_rst <= 1'h0;
    rd(8'h05, d);
    check(d, uw(8'h80, 1'h0, 8'h80, 1'h0, 1'h1));
    check(in_func_out[31:0], 32'h00000000);
    check({uout, vin}, 32'h00000000);
    final_report();
  end
endmodule : tb
